//--- verilog/ptp_clkout_status_frame_cfg.sv
/*
 * paged configuration bank: temporary-rate duration, divide-by-n clock
 * output control and status frame header templates.
 * assumes: management writes/reads arrive as one-cycle strobes on mclk_in,
 * root clock edges arrive as enables, reference cycles as ref_tick_in.
 */
//
// Contract
// - duration high ten bits in bits 9:0
// - duration low sixteen bits, one joint count
// - duration kept across temporary rate uses
// - duration counted in reference clock cycles
// - reserved bits ignore writes, read zero
// - config registers visible only on page six
// - bit 15 enables divided clock output
// - bit 14 picks phase generator or oscillator
// - bit 13 selects fast pin edges
// - output divides root clock by bits 7:0
// - divider values two through 255 supported
// - divider zero or one stops output
// - header word leads every status frame header
// - header word field layout, reset zero
// - status frames reach local mac receive path
// - first source address half, msb low
// - second source address half, third low
// - fourth register seeds ip checksum
// - checksum adds length and identification
`timescale 1ns/1ps
`include "ptp_cfg_consts.svh"

module ptp_clkout_status_frame_cfg import ptp_cfg_pkg::*; #(
    parameter int DIV_W = 8,
    parameter int DUR_W = `DUR_W
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // management register access
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    // temporary rate
    input wire logic temp_rate_start_in,
    input wire logic ref_tick_in,
    output logic temp_rate_active_out,
    output logic temp_rate_expired_out,
    // divided clock output
    input wire logic phase_gen_tick_in,
    input wire logic osc_tick_in,
    output logic clock_output_out,
    output logic clock_pin_edge_speed_out,
    // status frame templates
    output logic [3:0] header_message_kind_out,
    output logic [3:0] header_transport_field_out,
    output logic [3:0] header_version_field_out,
    output logic [3:0] header_reserved_nibble_out,
    output logic [15:0] header_word_out,
    output logic [7:0] source_addr_first_byte_out,
    output logic [7:0] source_addr_second_byte_out,
    output logic [7:0] source_addr_third_byte_out,
    output logic [7:0] source_addr_fourth_byte_out,
    // ip checksum assist
    input wire logic [15:0] total_length_in,
    input wire logic [15:0] identification_in,
    output logic [15:0] ip_checksum_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // address hit on a given page
    function automatic logic hit(input logic [4:0] addr,
        input logic [`PAGE_W-1:0] page, input logic [4:0] want_addr,
        input logic [`PAGE_W-1:0] want_page);
        hit = (addr == want_addr) && (page == want_page);
    endfunction

    // ones-complement 16-bit addition with end-around carry
    function automatic logic [15:0] ones_add(input logic [15:0] a,
        input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        ones_add = sum[15:0] + {15'h0000, sum[16]};
    endfunction

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [`PAGE_W-1:0] page_reg;
    logic [15:0] trdl_reg;
    logic [9:0] trdh_reg;
    logic [15:0] coc_reg;
    logic [15:0] hdr_reg;
    logic [15:0] sa_high_reg;
    logic [15:0] sa_low_reg;
    logic [15:0] seed_reg;
    logic [15:0] rdata_next;
    logic [15:0] csum_next;
    logic root_tick;

    // page selection, reachable from every page
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            page_reg <= '0;
        end else if (reg_wr_in && reg_addr_in == `PAGE_SEL_ADDR) begin
            page_reg <= reg_wdata_in[`PAGE_W-1:0];
        end
    end

    // temporary-rate duration registers, page five
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            trdl_reg <= `ZERO16;
            trdh_reg <= '0;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, page_reg, `TRDL_ADDR, `PAGE_TEMP_RATE)) begin
                trdl_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, page_reg, `TRDH_ADDR, `PAGE_TEMP_RATE)) begin
                trdh_reg <= reg_wdata_in[`TRDH_MSB:0];
            end
        end
    end

    // clock output control, page six
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            coc_reg <= `COC_RESET;
        end else if (reg_wr_in &&
            hit(reg_addr_in, page_reg, `COC_ADDR, `PAGE_CONFIG)) begin
            coc_reg <= reg_wdata_in & `COC_WMASK;
        end
    end

    // status frame templates, page six
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hdr_reg <= `ZERO16;
            sa_high_reg <= `ZERO16;
            sa_low_reg <= `ZERO16;
            seed_reg <= `ZERO16;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, page_reg, `HDR_ADDR, `PAGE_CONFIG)) begin
                hdr_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, page_reg, `SA_HIGH_ADDR, `PAGE_CONFIG)) begin
                sa_high_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, page_reg, `SA_LOW_ADDR, `PAGE_CONFIG)) begin
                sa_low_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, page_reg, `SEED_ADDR, `PAGE_CONFIG)) begin
                seed_reg <= reg_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // read mux; other pages and unmapped offsets read zero
    always_comb begin
        rdata_next = `ZERO16;
        if (reg_addr_in == `PAGE_SEL_ADDR) begin
            rdata_next = {13'h0000, page_reg};
        end else if (page_reg == `PAGE_TEMP_RATE) begin
            if (reg_addr_in == `TRDL_ADDR) begin
                rdata_next = trdl_reg;
            end else if (reg_addr_in == `TRDH_ADDR) begin
                rdata_next = {6'h00, trdh_reg};
            end
        end else if (page_reg == `PAGE_CONFIG) begin
            case (reg_addr_in)
                `COC_ADDR: rdata_next = coc_reg;
                `HDR_ADDR: rdata_next = hdr_reg;
                `SA_HIGH_ADDR: rdata_next = sa_high_reg;
                `SA_LOW_ADDR: rdata_next = sa_low_reg;
                `SEED_ADDR: rdata_next = seed_reg;
                default: rdata_next = `ZERO16;
            endcase
        end
    end

    // registered read data, one cycle after the read strobe
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_out <= `ZERO16;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // temporary rate duration
    // ------------------------------------------------------------------

    // the rate logic arms the timer; software loads duration beforehand
    temp_rate_timer #(
        .DUR_W(DUR_W)
    ) u_timer (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(temp_rate_start_in),
        .ref_tick_in(ref_tick_in),
        .duration_in({trdh_reg, trdl_reg}),
        .active_out(temp_rate_active_out),
        .expire_out(temp_rate_expired_out)
    );

    // ------------------------------------------------------------------
    // divided clock output
    // ------------------------------------------------------------------

    // root source choice for the divider
    assign root_tick = coc_reg[`COC_SEL_BIT] ? phase_gen_tick_in
        : osc_tick_in;

    clkout_divider #(
        .DIV_W(DIV_W)
    ) u_divider (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .root_tick_in(root_tick),
        .enable_in(coc_reg[`COC_EN_BIT]),
        .div_in(coc_reg[`COC_DIV_MSB:0]),
        .clk_out(clock_output_out)
    );

    // pad speed control straight from the register
    assign clock_pin_edge_speed_out = coc_reg[`COC_SPEED_BIT];

    // ------------------------------------------------------------------
    // status frame templates
    // ------------------------------------------------------------------

    // header fields for the frame builder on the receive data path
    assign header_word_out = hdr_reg;
    assign header_message_kind_out = hdr_reg[3:0];
    assign header_transport_field_out = hdr_reg[7:4];
    assign header_version_field_out = hdr_reg[11:8];
    assign header_reserved_nibble_out = hdr_reg[15:12];

    // ipv4 source address bytes, most significant first
    assign source_addr_first_byte_out = sa_high_reg[7:0];
    assign source_addr_second_byte_out = sa_high_reg[15:8];
    assign source_addr_third_byte_out = sa_low_reg[7:0];
    assign source_addr_fourth_byte_out = sa_low_reg[15:8];

    // final checksum: seed plus length plus identification
    assign csum_next = ones_add(ones_add(seed_reg, total_length_in),
        identification_in);

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ip_checksum_out <= `ZERO16;
        end else begin
            ip_checksum_out <= csum_next;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    AST_TRDH_RESERVED: assert property (reg_rd_in &&
        reg_addr_in == `TRDH_ADDR |=> reg_rdata_out[15:10] == 6'h00)
        else $error("duration high reserved bits read nonzero");
    AST_COC_RESERVED: assert property (coc_reg[12:8] == 5'h00)
        else $error("clock control reserved bits hold data");
    AST_PAGE_GATE: assert property (reg_wr_in &&
        page_reg != `PAGE_CONFIG && reg_addr_in == `HDR_ADDR
        |=> $stable(hdr_reg))
        else $error("header word written off its page");
    AST_PAGE_READ: assert property (reg_rd_in &&
        page_reg != `PAGE_CONFIG && reg_addr_in == `COC_ADDR
        |=> reg_rdata_out == `ZERO16)
        else $error("clock control visible off its page");
    AST_DUR_WRITE: assert property (reg_wr_in &&
        page_reg == `PAGE_TEMP_RATE && reg_addr_in == `TRDH_ADDR
        |=> trdh_reg == $past(reg_wdata_in[9:0]))
        else $error("duration high write lost");
    AST_DUR_KEPT: assert property (temp_rate_expired_out
        |-> $stable(trdl_reg) && $stable(trdh_reg))
        else $error("duration disturbed by expiry");
    AST_SPEED_PIN: assert property (reg_wr_in &&
        page_reg == `PAGE_CONFIG && reg_addr_in == `COC_ADDR
        |=> clock_pin_edge_speed_out == $past(reg_wdata_in[13]))
        else $error("edge speed control not following write");
    AST_OFF_LOW: assert property (!coc_reg[`COC_EN_BIT] ##1
        !coc_reg[`COC_EN_BIT] |-> !clock_output_out)
        else $error("divided clock runs while disabled");
    AST_CHECKSUM: assert property (ip_checksum_out == $past(ones_add(
        ones_add(seed_reg, total_length_in), identification_in)))
        else $error("checksum not seed plus length plus id");
    AST_SA_ORDER: assert property (reg_wr_in &&
        page_reg == `PAGE_CONFIG && reg_addr_in == `SA_HIGH_ADDR
        |=> source_addr_first_byte_out == $past(reg_wdata_in[7:0])
        && source_addr_second_byte_out == $past(reg_wdata_in[15:8]))
        else $error("source address byte order wrong");

    COV_PAGE6_WRITE: cover property (reg_wr_in && page_reg == `PAGE_CONFIG
        && reg_addr_in == `COC_ADDR);
    COV_TEMP_RATE: cover property (temp_rate_start_in ##[1:20]
        temp_rate_expired_out);
    COV_PHASE_ROOT: cover property (coc_reg[`COC_SEL_BIT] && clock_output_out);

endmodule // ptp_clkout_status_frame_cfg

//--- verilog/ptp_cfg_consts.svh
/*
 * register offsets, field positions, reset values and clock rates
 * for the clock output and status frame configuration bank.
 * assumes: included by bare name, before any package import.
 */
`ifndef PTP_CFG_CONSTS_SVH
`define PTP_CFG_CONSTS_SVH

// ----------------------------------------------------------------------
// page selection
// ----------------------------------------------------------------------
`define PAGE_SEL_ADDR 5'h13
`define PAGE_W 3
`define PAGE_TEMP_RATE 3'h5
`define PAGE_CONFIG 3'h6

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TRDL_ADDR 5'h1E
`define TRDH_ADDR 5'h1F
`define COC_ADDR 5'h14
`define HDR_ADDR 5'h15
`define SA_HIGH_ADDR 5'h16
`define SA_LOW_ADDR 5'h17
`define SEED_ADDR 5'h18

// ----------------------------------------------------------------------
// fields, masks and reset values
// ----------------------------------------------------------------------
`define COC_EN_BIT 15
`define COC_SEL_BIT 14
`define COC_SPEED_BIT 13
`define COC_DIV_MSB 7
`define COC_RESET 16'h800A
`define COC_WMASK 16'hE0FF
`define TRDH_MSB 9
`define TRDH_WMASK 16'h03FF
`define DUR_W 26
`define DIV_MIN 8'h02
`define ZERO16 16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ROOT_CLK_MHZ 250
`define MCLK_MHZ 20

`endif

//--- verilog/ptp_cfg_pkg.sv
/*
 * types shared by the configuration bank and its helpers.
 * assumes: compiled before every module that imports it.
 */
package ptp_cfg_pkg;
    // duration timer states
    typedef enum logic [0:0] {
        TIMER_IDLE,
        TIMER_RUN
    } timer_state_type;
endpackage

//--- verilog/clkout_divider.sv
/*
 * divide-by-n clock output, stepped by root clock edge enables.
 * assumes: one root tick per root clock edge, div and enable stable-ish.
 */
`timescale 1ns/1ps
`include "ptp_cfg_consts.svh"

module clkout_divider import ptp_cfg_pkg::*; #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // control
    input wire logic root_tick_in,
    input wire logic enable_in,
    input wire logic [DIV_W-1:0] div_in,
    // divided clock
    output logic clk_out
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic run;

    // divider runs only when enabled and value is legal
    assign run = enable_in && (div_in >= `DIV_MIN);
    assign cnt_next = (cnt_reg >= div_in - 1'b1) ? '0 : cnt_reg + 1'b1;

    // phase counter and output level; parked at all ones while stopped
    // so the first tick after a restart opens a high phase
    always_ff @(posedge mclk_in) begin
        if (rst_in || !run) begin
            cnt_reg <= '1;
            clk_out <= 1'b0;
        end else if (root_tick_in) begin
            cnt_reg <= cnt_next;
            clk_out <= cnt_next < (div_in >> 1);
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    AST_STOPPED_LOW: assert property (!run |=> !clk_out)
        else $error("divided clock toggles while stopped");
    AST_DIV2_TOGGLE: assert property (run && root_tick_in &&
        div_in == 8'h02 && $stable(div_in) |=> clk_out != $past(clk_out))
        else $error("divide by two does not toggle each tick");
    COV_DIV_RUN: cover property (run && root_tick_in && clk_out);
endmodule // clkout_divider

//--- verilog/temp_rate_timer.sv
/*
 * temporary-rate duration timer counting reference clock cycles.
 * assumes: start pulse comes from the rate logic on its low-word write.
 */
`timescale 1ns/1ps
`include "ptp_cfg_consts.svh"

module temp_rate_timer import ptp_cfg_pkg::*; #(
    parameter int DUR_W = `DUR_W
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // control
    input wire logic start_in,
    input wire logic ref_tick_in,
    input wire logic [DUR_W-1:0] duration_in,
    // status
    output logic active_out,
    output logic expire_out
);
    timer_state_type state_reg;
    logic [DUR_W-1:0] remain_reg;

    // load on start, count reference cycles, fall back when done
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= TIMER_IDLE;
            remain_reg <= '0;
            expire_out <= 1'b0;
        end else begin
            expire_out <= 1'b0;
            case (state_reg)
                TIMER_IDLE: begin
                    if (start_in && duration_in != '0) begin
                        remain_reg <= duration_in;
                        state_reg <= TIMER_RUN;
                    end
                end
                TIMER_RUN: begin
                    if (start_in) begin
                        remain_reg <= duration_in;
                        if (duration_in == '0) begin
                            state_reg <= TIMER_IDLE;
                        end
                    end else if (ref_tick_in) begin
                        remain_reg <= remain_reg - 1'b1;
                        if (remain_reg == {{(DUR_W-1){1'b0}}, 1'b1}) begin
                            state_reg <= TIMER_IDLE;
                            expire_out <= 1'b1;
                        end
                    end
                end
                default: state_reg <= TIMER_IDLE;
            endcase
        end
    end

    assign active_out = (state_reg == TIMER_RUN);

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    AST_EXPIRE_ENDS: assert property (expire_out |-> !active_out)
        else $error("rate still temporary after expiry");
    AST_ONE_CYCLE: assert property (!active_out && start_in &&
        duration_in == 26'h0000001 ##1 ref_tick_in && !start_in
        |=> !active_out && expire_out)
        else $error("one cycle duration not honoured");
    COV_EXPIRE: cover property (expire_out);
endmodule // temp_rate_timer

//--- tb/status_frame_sink.sv
/*
 * local mac view of the status frame templates: first two header
 * octets and the ipv4 source address in wire order.
 * assumes: fed straight from the configuration bank outputs.
 */
`timescale 1ns/1ps

module status_frame_sink (
    // header fields
    input wire logic [3:0] kind_in,
    input wire logic [3:0] transport_in,
    input wire logic [3:0] version_in,
    input wire logic [3:0] reserved_in,
    // source address bytes
    input wire logic [7:0] sa0_in,
    input wire logic [7:0] sa1_in,
    input wire logic [7:0] sa2_in,
    input wire logic [7:0] sa3_in,
    // frame content as received
    output logic [15:0] header_lead_out,
    output logic [31:0] source_addr_out
);
    // octet 0 then octet 1, reserved nibble in octet 1
    assign header_lead_out = {transport_in, kind_in,
        reserved_in, version_in};
    // most significant address byte first
    assign source_addr_out = {sa0_in, sa1_in, sa2_in, sa3_in};
endmodule // status_frame_sink

//--- tb/tb.sv
/*
 * self-checking bench: registers, paging, duration timer, divided
 * clock and status frame templates against an integer model.
 * assumes: design files and the constants header compiled first.
 */
`timescale 1ns/1ps
`include "ptp_cfg_consts.svh"

module tb;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic mclk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic [4:0] reg_addr_in = 0;
    logic [15:0] reg_wdata_in = 0, reg_rdata_out, hword, csum_q;
    logic temp_rate_start_in = 0, ref_tick_in = 0, act, expd;
    logic phase_gen_tick_in = 0, osc_tick_in = 0, clk_o, speed;
    logic [3:0] hk, ht, hv, hr;
    logic [7:0] sa0, sa1, sa2, sa3;
    logic [15:0] total_length_in = 0, identification_in = 0, lead;
    logic [31:0] saddr;
    int errors = 0, n_compared = 0, seed = 68389, cycles = 0;
    int page = 0, highs, tg, m5 [int], m6 [int];
    int divs [6] = '{2, 3, 10, 255, 0, 1};

    ptp_clkout_status_frame_cfg u_ptp_clkout_status_frame_cfg (
        .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .temp_rate_start_in(temp_rate_start_in), .ref_tick_in(ref_tick_in),
        .temp_rate_active_out(act), .temp_rate_expired_out(expd),
        .phase_gen_tick_in(phase_gen_tick_in), .osc_tick_in(osc_tick_in),
        .clock_output_out(clk_o), .clock_pin_edge_speed_out(speed),
        .header_message_kind_out(hk), .header_transport_field_out(ht),
        .header_version_field_out(hv), .header_reserved_nibble_out(hr),
        .header_word_out(hword), .source_addr_first_byte_out(sa0),
        .source_addr_second_byte_out(sa1), .source_addr_third_byte_out(sa2),
        .source_addr_fourth_byte_out(sa3), .total_length_in(total_length_in),
        .identification_in(identification_in), .ip_checksum_out(csum_q));

    status_frame_sink u_status_frame_sink (
        .kind_in(hk), .transport_in(ht), .version_in(hv), .reserved_in(hr),
        .sa0_in(sa0), .sa1_in(sa1), .sa2_in(sa2), .sa3_in(sa3),
        .header_lead_out(lead), .source_addr_out(saddr));

    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    always #25 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("Error %0t run did not finish", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int wmask(int a);
        if (a == `COC_ADDR) return `COC_WMASK;
        if (a == `TRDH_ADDR) return `TRDH_WMASK;
        return 16'hFFFF;
    endfunction

    function automatic int expect_rd(int a);
        if (a == `PAGE_SEL_ADDR) return page;
        if (page == 5 && m5.exists(a)) return m5[a];
        if (page == 6 && m6.exists(a)) return m6[a];
        return 0;
    endfunction

    // ones-complement sum with end-around carry
    function automatic logic [15:0] csum(int s, int l, int i);
        int t;
        t = s + l + i;
        t = (t & 16'hFFFF) + (t >> 16);
        t = (t & 16'hFFFF) + (t >> 16);
        return t[15:0];
    endfunction

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        if (a == `PAGE_SEL_ADDR) page = d & 7;
        else if (page == 5 && m5.exists(a)) m5[a] = d & wmask(a);
        else if (page == 6 && m6.exists(a)) m6[a] = d & wmask(a);
    endtask

    task automatic rd_check(input logic [4:0] a);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 check(reg_rdata_out, expect_rd(a));
    endtask

    task automatic templ_check();
        logic [15:0] h, s2, s3;
        h = m6[`HDR_ADDR];
        s2 = m6[`SA_HIGH_ADDR];
        s3 = m6[`SA_LOW_ADDR];
        check(hword, h);
        check({hr, hv, ht, hk}, h);
        check(lead, {h[7:0], h[15:8]});
        check(saddr, {s2[7:0], s2[15:8], s3[7:0], s3[15:8]});
        check(csum_q, csum(m6[`SEED_ADDR], total_length_in,
            identification_in));
    endtask

    // start, then count reference ticks until the rate reverts
    task automatic run_timer(input int d, input bit rnd);
        int left;
        bit tk;
        left = d;
        @(posedge mclk_in);
        temp_rate_start_in <= 1'b1;
        ref_tick_in <= 1'b1;
        @(posedge mclk_in);
        temp_rate_start_in <= 1'b0;
        for (int i = 0; i < 200 && left > 0; i++) begin
            tk = rnd ? $random(seed) : 1'b1;
            ref_tick_in <= tk;
            #1 check({act, expd}, 2'b10);
            @(posedge mclk_in);
            if (tk) left--;
        end
        ref_tick_in <= 1'b0;
        #1 check({act, expd}, 2'b01);
    endtask

    // settle, then count high samples and level changes
    task automatic clk_measure(input int len);
        logic last;
        repeat (len / 2 + 4) @(posedge mclk_in);
        #1 last = clk_o;
        highs = 0;
        tg = 0;
        repeat (len) begin
            @(posedge mclk_in);
            #1 highs += (clk_o === 1'b1);
            tg += (clk_o !== last);
            last = clk_o;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        m5[`TRDL_ADDR] = 0;
        m5[`TRDH_ADDR] = 0;
        for (int a = 21; a <= 24; a++) m6[a] = 0;
        m6[`COC_ADDR] = `COC_RESET;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        wr(`HDR_ADDR, 16'h1234);
        rd_check(`HDR_ADDR);
        rd_check(`COC_ADDR);
        wr(`PAGE_SEL_ADDR, 16'hFFFE);
        rd_check(`PAGE_SEL_ADDR);
        for (int a = 20; a <= 25; a++) rd_check(a[4:0]);
        wr(`COC_ADDR, 16'hFFFF);
        rd_check(`COC_ADDR);
        repeat (6) begin
            @(posedge mclk_in);
            total_length_in <= 16'($random(seed));
            identification_in <= 16'($random(seed));
            for (int a = 21; a <= 24; a++) wr(a[4:0], 16'($random(seed)));
            @(posedge mclk_in);
            #1 templ_check();
            rd_check(`SEED_ADDR);
        end
        wr(`PAGE_SEL_ADDR, 16'h0005);
        wr(`TRDH_ADDR, 16'hFFFF);
        rd_check(`TRDH_ADDR);
        wr(`TRDH_ADDR, 16'h0000);
        wr(`TRDL_ADDR, 16'h0006);
        rd_check(`TRDL_ADDR);
        run_timer(6, 1'b1);
        run_timer(6, 1'b0);
        wr(`TRDL_ADDR, 16'h0001);
        run_timer(1, 1'b0);
        wr(`PAGE_SEL_ADDR, 16'h0006);
        osc_tick_in <= 1'b1;
        foreach (divs[k]) begin
            wr(`COC_ADDR, 16'(16'h8000 | divs[k]));
            clk_measure(divs[k] < 2 ? 32 : 4 * divs[k]);
            check(highs, divs[k] < 2 ? 0 : divs[k] / 2 * 4);
        end
        check(speed, 1'b0);
        wr(`COC_ADDR, 16'h000A);
        clk_measure(40);
        check(highs, 0);
        wr(`COC_ADDR, 16'hE002);
        clk_measure(8);
        check(tg, 0);
        check(speed, 1'b1);
        @(posedge mclk_in);
        phase_gen_tick_in <= 1'b1;
        osc_tick_in <= 1'b0;
        clk_measure(8);
        check(highs, 4);
        complete_run();
    end
endmodule // tb
